/* common/speed_cmd_map.vh */
/*
 * Register offsets, field positions, reset values and timing counts for the speed command selector
 * and position gain block.
 * Assumes inclusion by bare name from design files; holds definitions only.
 */
`ifndef SPEED_CMD_MAP_VH
`define SPEED_CMD_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_POS_PROP_GAIN    12'h0128
`define OFF_POS_FF_GAIN      12'h012c
`define OFF_SPEED_PRESET_1   12'h0140
`define OFF_SPEED_PRESET_2   12'h0144
`define OFF_SPEED_PRESET_3   12'h0148
`define OFF_ANALOG_SCALE     12'h014c
`define OFF_CONTROL          12'h0150
`define OFF_STATUS           12'h0154
`define OFF_POS_ERROR        12'h0158
`define OFF_CMD_RATE         12'h015c
`define OFF_POS_SPEED_CMD    12'h0160
`define OFF_GAIN_ADJ         12'h0164

// ****************************************
// Reset values and limits
// ****************************************
`define RST_POS_PROP_GAIN    16'h007d
`define RST_POS_FF_GAIN      16'h0032
`define MAX_POS_PROP_GAIN    16'h07ff
`define MAX_POS_FF_GAIN      16'h0064
`define RST_ANALOG_SCALE     16'h0bb8
`define PRESET_MAX           18'h0_c350
`define PRESET_MIN           18'h3_3cb0

// ****************************************
// Control register fields
// ****************************************
`define CTL_ZERO_REF         0
`define CTL_TORQUE           1
`define CTL_AUTO_GAIN        2
`define CTL_SMOOTH_STEP      7:4

// ****************************************
// Timing
// ****************************************
`define SMOOTH_TICK_NS       100000
`define CLK_PERIOD_NS        100
`define SMOOTH_TICK_CYCLES   (`SMOOTH_TICK_NS / `CLK_PERIOD_NS)

`endif

/* logic/pin_sync.v */
/*
 * Three flip-flop input synchroniser with agreement filter for a contact input.
 * Assumes an asynchronous pin level and a single clock domain.
 */
`timescale 1ns/100ps
module pin_sync (
	// Clock and reset
	input  wire clk_sys,
	input  wire rst_n,
	// Pin and clean level
	input  wire pin_in,
	output reg  level
);
	reg s1;
	reg s2;
	reg s3;

	// The first stage feeds only the second; a level counts once stages two and three agree.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule // pin_sync

/* logic/speed_command_select.v */
/*
 * Speed command selector and position loop gain block with APB register access.
 * Assumes a 10 MHz clock, an already digitised signed analog reference and position error
 * and command rate samples supplied by the motor loop.
 */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "speed_cmd_map.vh"
module speed_command_select (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// Speed select contacts, high when closed
	input  wire        speed_select_low,
	input  wire        speed_select_high,
	// Digitised analog reference, signed millivolts of reference minus ground
	input  wire [15:0] analog_ref_mv,
	// Motor loop samples
	input  wire [15:0] pos_error,
	input  wire [15:0] cmd_rate,
	// Gain tuning estimate supplied by the inertia estimator, signed gain offset
	input  wire [15:0] tuned_gain_delta,
	// Outputs to the loops
	output reg  [17:0] speed_cmd,
	output reg  [17:0] speed_limit,
	output reg         speed_limit_active,
	output reg  [15:0] pos_prop_gain,
	output reg  [15:0] pos_ff_gain,
	output reg  [31:0] pos_speed_cmd,
	output reg         auto_tune_enable
);
	// ****************************************
	// Registers
	// ****************************************
	reg [15:0] gain_prop_user;
	reg [15:0] gain_ff_user;
	reg [17:0] speed_preset_one;
	reg [17:0] speed_preset_two;
	reg [17:0] speed_preset_three;
	reg [15:0] analog_speed_scale;
	reg [7:0]  control;
	reg [17:0] smoothed_preset;
	reg [13:0] tick_count;
	reg [1:0]  last_sel;
	reg        smoothing;

	wire sel_low;
	wire sel_high;
	wire [1:0]  speed_sel;
	wire        apb_write;
	wire        zero_ref_speed_mode;
	wire        torque_mode;
	wire        gain_tuning_mode_param;
	wire [17:0] selected_preset;
	wire signed [33:0] analog_product;
	wire [17:0] analog_speed;
	reg  [17:0] next_cmd;
	wire signed [17:0] step_size;
	wire signed [33:0] prop_term;
	wire signed [33:0] ff_term;
	wire signed [16:0] gain_sum;

	// Contact inputs pass the three-stage filter; closed contact gives a 1.
	pin_sync u_sync_low (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (speed_select_low),
		.level   (sel_low)
	);
	pin_sync u_sync_high (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (speed_select_high),
		.level   (sel_high)
	);
	assign speed_sel = {sel_high, sel_low};

	assign zero_ref_speed_mode    = control[`CTL_ZERO_REF];
	assign torque_mode            = control[`CTL_TORQUE];
	assign gain_tuning_mode_param = control[`CTL_AUTO_GAIN];

	// Preset values are checked on write; out-of-range writes are ignored with an error answer.
	function in_preset_range;
		input [31:0] v;
		begin
			in_preset_range = ($signed(v) <= $signed({14'h0000, `PRESET_MAX})) &&
				($signed(v) >= $signed({14'h3fff, `PRESET_MIN}));
		end
	endfunction

	// ****************************************
	// APB slave
	// ****************************************
	// Zero wait states; bad value or unmapped address answers with pslverr.
	assign pready    = 1'b1;
	assign apb_write = psel & penable & pwrite;
	reg write_bad;
	always @* begin
		write_bad = 1'b0;
		case (paddr)
			`OFF_POS_PROP_GAIN: write_bad = (pwdata > {16'h0000, `MAX_POS_PROP_GAIN});
			`OFF_POS_FF_GAIN:   write_bad = (pwdata > {16'h0000, `MAX_POS_FF_GAIN});
			`OFF_SPEED_PRESET_1,
			`OFF_SPEED_PRESET_2,
			`OFF_SPEED_PRESET_3: write_bad = !in_preset_range(pwdata);
			`OFF_ANALOG_SCALE, `OFF_CONTROL: write_bad = 1'b0;
			`OFF_STATUS, `OFF_POS_ERROR, `OFF_CMD_RATE, `OFF_POS_SPEED_CMD, `OFF_GAIN_ADJ:
				write_bad = pwrite;
			default: write_bad = 1'b1;
		endcase
	end
	assign pslverr = psel & penable & write_bad;

	// Register writes happen in the access phase only.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gain_prop_user     <= `RST_POS_PROP_GAIN;
			gain_ff_user       <= `RST_POS_FF_GAIN;
			speed_preset_one   <= 18'h0_0000;
			speed_preset_two   <= 18'h0_0000;
			speed_preset_three <= 18'h0_0000;
			analog_speed_scale <= `RST_ANALOG_SCALE;
			control            <= 8'h01;
		end else if (apb_write && !write_bad) begin
			case (paddr)
				`OFF_POS_PROP_GAIN:  gain_prop_user     <= pwdata[15:0];
				`OFF_POS_FF_GAIN:    gain_ff_user       <= pwdata[15:0];
				`OFF_SPEED_PRESET_1: speed_preset_one   <= pwdata[17:0];
				`OFF_SPEED_PRESET_2: speed_preset_two   <= pwdata[17:0];
				`OFF_SPEED_PRESET_3: speed_preset_three <= pwdata[17:0];
				`OFF_ANALOG_SCALE:   analog_speed_scale <= pwdata[15:0];
				`OFF_CONTROL:        control            <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Read data is combinational from the registers, valid in the access phase.
	always @* begin
		case (paddr)
			`OFF_POS_PROP_GAIN:  prdata = {16'h0000, gain_prop_user};
			`OFF_POS_FF_GAIN:    prdata = {16'h0000, gain_ff_user};
			`OFF_SPEED_PRESET_1: prdata = {{14{speed_preset_one[17]}}, speed_preset_one};
			`OFF_SPEED_PRESET_2: prdata = {{14{speed_preset_two[17]}}, speed_preset_two};
			`OFF_SPEED_PRESET_3: prdata = {{14{speed_preset_three[17]}}, speed_preset_three};
			`OFF_ANALOG_SCALE:   prdata = {16'h0000, analog_speed_scale};
			`OFF_CONTROL:        prdata = {24'h00_0000, control};
			`OFF_STATUS:         prdata = {{14{speed_cmd[17]}}, speed_cmd[17:0] ^ 18'h0_0000} & 32'h0003_ffff |
				{9'h000, smoothing, speed_sel, 20'h0_0000} & 32'h007c_0000 | 32'h0000_0000;
			`OFF_POS_ERROR:      prdata = {16'h0000, pos_error};
			`OFF_CMD_RATE:       prdata = {16'h0000, cmd_rate};
			`OFF_POS_SPEED_CMD:  prdata = pos_speed_cmd;
			`OFF_GAIN_ADJ:       prdata = {16'h0000, pos_prop_gain};
			default:             prdata = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Speed command selection
	// ****************************************
	// Preset chosen straight from the select pair, no extra delay.
	assign selected_preset = (speed_sel == 2'b01) ? speed_preset_one :
		(speed_sel == 2'b10) ? speed_preset_two : speed_preset_three;

	// Analog reference in mV times scale (r/min at 10 V) gives 0.1 r/min counts: mv*scale/1024, close to /1000.
	assign analog_product = $signed(analog_ref_mv) * $signed({2'b00, analog_speed_scale});
	assign analog_speed   = analog_product[27:10];

	// Smoothing ramps toward a preset that was rewritten while selected; selection changes jump.
	assign step_size = $signed({10'h000, control[`CTL_SMOOTH_STEP], 4'h0});
	always @* begin
		next_cmd = smoothed_preset;
		if (speed_sel != last_sel || control[`CTL_SMOOTH_STEP] == 4'h0) begin
			next_cmd = selected_preset;
		end else if (tick_count == 14'h0000) begin
			if ($signed(selected_preset) > $signed(smoothed_preset) + step_size) begin
				next_cmd = smoothed_preset + step_size;
			end else if ($signed(selected_preset) < $signed(smoothed_preset) - step_size) begin
				next_cmd = smoothed_preset - step_size;
			end else begin
				next_cmd = selected_preset;
			end
		end
	end

	// Ramp state and smoothing tick counter.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			smoothed_preset <= 18'h0_0000;
			tick_count      <= 14'h0000;
			last_sel        <= 2'b00;
			smoothing       <= 1'b0;
		end else begin
			smoothed_preset <= next_cmd;
			last_sel        <= speed_sel;
			smoothing       <= (next_cmd != selected_preset);
			if (tick_count == `SMOOTH_TICK_CYCLES - 1) begin
				tick_count <= 14'h0000;
			end else begin
				tick_count <= tick_count + 14'h0001;
			end
		end
	end

	// Final command always drives speed_cmd as target; in torque mode speed_limit also takes it one cycle later.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			speed_cmd          <= 18'h0_0000;
			speed_limit        <= 18'h0_0000;
			speed_limit_active <= 1'b0;
		end else begin
			if (speed_sel == 2'b00) begin
				speed_cmd <= zero_ref_speed_mode ? 18'h0_0000 : analog_speed;
			end else if (last_sel != speed_sel) begin
				speed_cmd <= selected_preset;
			end else begin
				speed_cmd <= next_cmd;
			end
			speed_limit        <= torque_mode ? speed_cmd : 18'h0_0000;
			speed_limit_active <= torque_mode;
		end
	end

	// ****************************************
	// Position loop gains
	// ****************************************
	// Manual mode passes user gains only; auto mode offsets the proportional gain by the estimator, clamped.
	assign gain_sum = $signed({1'b0, gain_prop_user}) + $signed(tuned_gain_delta[15:0]);
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pos_prop_gain    <= `RST_POS_PROP_GAIN;
			pos_ff_gain      <= `RST_POS_FF_GAIN;
			auto_tune_enable <= 1'b0;
		end else begin
			pos_ff_gain      <= gain_ff_user;
			auto_tune_enable <= gain_tuning_mode_param;
			if (!gain_tuning_mode_param) begin
				pos_prop_gain <= gain_prop_user;
			end else if (gain_sum[16]) begin
				pos_prop_gain <= 16'h0000;
			end else if (gain_sum[15:0] > `MAX_POS_PROP_GAIN) begin
				pos_prop_gain <= `MAX_POS_PROP_GAIN;
			end else begin
				pos_prop_gain <= gain_sum[15:0];
			end
		end
	end

	// Feed-forward share of the command rate cuts following lag; percent taken as /128 approx avoided: exact /100.
	assign prop_term = $signed(pos_error) * $signed({2'b00, pos_prop_gain});
	assign ff_term   = ($signed(cmd_rate) * $signed({2'b00, pos_ff_gain})) / $signed(34'sd100);
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pos_speed_cmd <= 32'h0000_0000;
		end else begin
			pos_speed_cmd <= prop_term[31:0] + ff_term[31:0];
		end
	end
endmodule // speed_command_select

/* verif/host_ctl_model.sv */
/*
 * Host controller model: contact inputs and analog reference for the drive.
 * Assumes the bench gives the select code and reference in millivolts.
 */
`timescale 1ns/100ps
module host_ctl_model (
	// Clock
	input  wire         clk_sys,
	// Bench commands
	input  wire  [1:0]  sel_code,
	input  wire  [15:0] ref_mv,
	// Toward the drive
	output logic        speed_select_low,
	output logic        speed_select_high,
	output logic [15:0] analog_ref_mv
);
	// Levels move just after an edge; a closed contact reads as 1.
	// The first edge comes well inside reset, so the drive never acts on the unset start level.
	always @(posedge clk_sys) begin
		speed_select_low <= sel_code[0];
		speed_select_high <= sel_code[1];
		analog_ref_mv <= ref_mv;
	end
endmodule // host_ctl_model

/* verif/speed_command_select_asserts.sv */
/*
 * Checker for the speed command and position gain block.
 * Assumes it is bound to speed_command_select and sees only its ports.
 */
`timescale 1ns/100ps
module speed_command_select_asserts (
	// Clock and reset
	input wire        clk_sys,
	input wire        rst_n,
	// APB
	input wire        psel,
	input wire        penable,
	input wire        pready,
	// Loop samples and outputs
	input wire [15:0] pos_error,
	input wire [15:0] cmd_rate,
	input wire [17:0] speed_cmd,
	input wire [17:0] speed_limit,
	input wire        speed_limit_active,
	input wire [15:0] pos_prop_gain,
	input wire [15:0] pos_ff_gain,
	input wire [31:0] pos_speed_cmd,
	input wire        auto_tune_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic signed [31:0] exp_cmd;
	logic signed [31:0] exp_d1;
	logic signed [31:0] exp_d2;
	logic        [1:0]  age;
	// Expected loop command from the present samples and effective gains.
	always @* begin
		exp_cmd = $signed(pos_error) * $signed({16'h0000, pos_prop_gain})
			+ ($signed(cmd_rate) * $signed({16'h0000, pos_ff_gain})) / 100;
	end
	// Delayed copies show when inputs have settled; age hides the first cycles after reset.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			exp_d1 <= 32'sh0000_0000;
			exp_d2 <= 32'sh0000_0000;
			age <= 2'h0;
		end else begin
			exp_d1 <= exp_cmd;
			exp_d2 <= exp_d1;
			if (age != 2'h3) begin
				age <= age + 2'h1;
			end
		end
	end
	AST_ZERO_WAIT: assert property (psel && penable |-> pready) else $error("APB access not answered");
	AST_RESET_GAIN: assert property ($rose(rst_n) |-> pos_prop_gain == 16'h007d && pos_ff_gain == 16'h0032)
		else $error("Gains not at initial values");
	AST_TORQUE_LIMIT: assert property (speed_limit_active && $past(speed_limit_active)
		|-> speed_limit == $past(speed_cmd)) else $error("Speed limit does not follow command");
	AST_LIMIT_IDLE: assert property (!speed_limit_active && !$past(speed_limit_active)
		|-> speed_limit == 18'h0_0000) else $error("Speed limit set outside torque mode");
	AST_PROP_RANGE: assert property (!auto_tune_enable |-> pos_prop_gain <= 16'h07ff)
		else $error("Proportional gain out of range");
	AST_FF_RANGE: assert property (!auto_tune_enable |-> pos_ff_gain <= 16'h0064)
		else $error("Feed-forward gain out of range");
	AST_MANUAL_HOLD: assert property (!auto_tune_enable && !$past(auto_tune_enable) && !$past(psel)
		&& !$past(psel, 2) |-> $stable(pos_prop_gain)) else $error("Gain moved in manual mode");
	AST_LOOP_CMD: assert property (age == 2'h3 && exp_cmd == exp_d1 && exp_d1 == exp_d2
		|-> pos_speed_cmd == exp_cmd) else $error("Position loop command wrong");
endmodule // speed_command_select_asserts
bind speed_command_select speed_command_select_asserts u_speed_command_select_asserts (.clk_sys, .rst_n, .psel,
	.penable, .pready, .pos_error, .cmd_rate, .speed_cmd, .speed_limit, .speed_limit_active, .pos_prop_gain,
	.pos_ff_gain, .pos_speed_cmd, .auto_tune_enable);

/* verif/speed_command_select_test.sv */
/*
 * Self-checking bench for the speed command and position gain block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/100ps
`define CHK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end
module speed_command_select_test;
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic        speed_select_low, speed_select_high, speed_limit_active, auto_tune_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pos_speed_cmd, rd, seed;
	logic [15:0] analog_ref_mv, pos_error, cmd_rate, tuned_gain_delta, pos_prop_gain, pos_ff_gain, ref_mv;
	logic [17:0] speed_cmd, speed_limit;
	logic [1:0]  sel_code;
	int          n_mismatch, tests_run, k, e, r, kp, ff, mv;
	int          pre[3];
	logic [11:0] ta[6] = '{12'h128, 12'h128, 12'h12c, 12'h12c, 12'h140, 12'h140};
	logic [31:0] td[6] = '{32'h0000_07ff, 32'h0000_0800, 32'h0000_0064, 32'h0000_0065, 32'h0000_c351, 32'hffff_3caf};
	logic        te[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	speed_command_select u_speed_command_select (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .speed_select_low, .speed_select_high, .analog_ref_mv, .pos_error, .cmd_rate,
		.tuned_gain_delta, .speed_cmd, .speed_limit, .speed_limit_active, .pos_prop_gain, .pos_ff_gain,
		.pos_speed_cmd, .auto_tune_enable);
	host_ctl_model u_host_ctl_model (.clk_sys, .sel_code, .ref_mv, .speed_select_low, .speed_select_high,
		.analog_ref_mv);
	// ****************************************
	// Helpers
	// ****************************************
	task complete_run();
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function int span(int lo, int hi);
		return lo + int'(rnd() % (hi - lo + 1));
	endfunction
	// One APB transfer; the wait for pready is bounded so a dead slave ends the run.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic x);
		apb(1'b1, a, d);
		`CHK("pslverr", x, err)
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		`CHK("read", x, rd)
	endtask
	// The selector needs a few cycles to filter the contacts; a ramp needs far longer, so the bound is an argument.
	// A wait that runs out is counted and ends the run at once.
	task wait_cmd(input logic [17:0] x, input int lim = 10);
		for (int n = 0; n < lim && speed_cmd !== x; n++) @(posedge clk_sys);
		`CHK("speed_cmd", x, speed_cmd)
		if (speed_cmd !== x) complete_run();
	endtask
	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, sel_code, ref_mv} = '0;
		{pos_error, cmd_rate, tuned_gain_delta} = '0;
		seed = 32'h0000_0003;
		rst_n = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(12'h128, 32'h0000_007d);
		rdchk(12'h12c, 32'h0000_0032);
		wr(12'h200, 32'h0000_0001, 1'b1);
		for (k = 0; k < 6; k++) wr(ta[k], td[k], te[k]);
		rdchk(12'h128, 32'h0000_07ff);
		rdchk(12'h12c, 32'h0000_0064);
		pre = '{50000, -50000, span(-50000, 50000)};
		for (k = 0; k < 3; k++) begin
			wr(12'h140 + 12'(4 * k), 32'(pre[k]), 1'b0);
			rdchk(12'h140 + 12'(4 * k), 32'(pre[k]));
		end
		for (k = 1; k < 4; k++) begin
			sel_code <= k[1:0];
			wait_cmd(18'(pre[k - 1]));
		end
		sel_code <= 2'b00;
		wait_cmd(18'h0_0000);
		mv = span(-10000, 10000);
		ref_mv <= 16'(mv);
		wr(12'h150, 32'h0000_0000, 1'b0);
		wait_cmd(18'((mv * 3000) >>> 10));
		wr(12'h14c, 32'h0000_05dc, 1'b0);
		wait_cmd(18'((mv * 1500) >>> 10));
		wr(12'h150, 32'h0000_0002, 1'b0);
		repeat (3) @(posedge clk_sys);
		`CHK("limit_active", 1'b1, speed_limit_active)
		`CHK("speed_limit", 18'((mv * 1500) >>> 10), speed_limit)
		for (k = 0; k < 4; k++) begin
			kp = span(0, 2047);
			ff = span(0, 100);
			e = span(-1000, 1000);
			r = span(-1000, 1000);
			wr(12'h128, 32'(kp), 1'b0);
			wr(12'h12c, 32'(ff), 1'b0);
			pos_error <= 16'(e);
			cmd_rate <= 16'(r);
			tuned_gain_delta <= 16'(rnd());
			repeat (4) @(posedge clk_sys);
			`CHK("pos_speed_cmd", 32'(e * kp + (r * ff) / 100), pos_speed_cmd)
			`CHK("pos_prop_gain", 16'(kp), pos_prop_gain)
			`CHK("pos_ff_gain", 16'(ff), pos_ff_gain)
		end
		// A rewrite of the selected preset must ramp in steps of 240 counts per tick, not jump.
		wr(12'h150, 32'h0000_00f0, 1'b0);
		sel_code <= 2'b01;
		wait_cmd(18'(pre[0]));
		wr(12'h140, 32'(pre[0] - 1000), 1'b0);
		repeat (2) @(posedge clk_sys);
		`CHK("ramp", 1'b1, speed_cmd !== 18'(pre[0] - 1000))
		wait_cmd(18'(pre[0] - 1000), 6000);
		// Automatic mode offsets the user gain by the estimate, kept inside the legal range.
		r = span(-200, 200);
		tuned_gain_delta <= 16'(r);
		wr(12'h150, 32'h0000_0004, 1'b0);
		repeat (3) @(posedge clk_sys);
		`CHK("auto_tune", 1'b1, auto_tune_enable)
		k = kp + r;
		`CHK("auto_gain", 16'((k < 0) ? 0 : (k > 2047) ? 2047 : k), pos_prop_gain)
		complete_run();
	end
endmodule // speed_command_select_test
